// ### ais_pkg.sv
// constants for the analog input sequencer
package ais_pkg;
    // host byte ports
    localparam logic [7:0] AIS_CONVERSION_COMMAND_ADDR = 8'hd8;
    localparam logic [7:0] AIS_RESULT_LOW_AND_DONE_ADDR = 8'hd8;
    localparam logic [7:0] AIS_RESULT_HIGH_ADDR = 8'hd9;
    // command fields
    localparam int AIS_CMD_CHAN_LSB = 0;
    localparam int AIS_CMD_CONN_BIT = 4;
    localparam int AIS_CMD_EXP_LSB = 4;
    localparam int AIS_CMD_GAIN_LSB = 6;
    localparam logic [7:0] AIS_CMD_RESET = 8'h00;
    // low byte layout
    localparam int AIS_LOW_DONE_BIT = 0;
    localparam int AIS_LOW_RES_LSB = 4;
    localparam logic [7:0] AIS_UNMAPPED_READ = 8'h00;
    // converter clock: 1.024 MHz from 200 MHz by phase accumulation
    localparam int AIS_CLK_KHZ = 200000;
    localparam int AIS_SAR_KHZ = 1024;
    localparam logic [17:0] AIS_ACC_STEP = 18'(AIS_SAR_KHZ);
    localparam logic [17:0] AIS_ACC_WRAP = 18'(AIS_CLK_KHZ);
    // conversion length, counted in converter clock ticks (longest, rounds down)
    localparam int AIS_CONV_TIME_NS = 50000;
    localparam int AIS_CONV_TICKS_I = AIS_CONV_TIME_NS * AIS_SAR_KHZ / 1000000;
    localparam int AIS_RES_BITS = 12;
    localparam logic [5:0] AIS_CONV_TICKS = 6'(AIS_CONV_TICKS_I);
    localparam logic [5:0] AIS_SETTLE_TICKS = 6'(AIS_CONV_TICKS_I - AIS_RES_BITS);
    // break-before-make gap on expansion selects (least, rounds up)
    localparam int AIS_EXP_GAP_NS = 400;
    localparam int AIS_EXP_GAP_I = (AIS_EXP_GAP_NS * (AIS_CLK_KHZ / 1000) + 999) / 1000;
    localparam logic [6:0] AIS_EXP_GAP_CYC = 7'(AIS_EXP_GAP_I);
    localparam logic [3:0] AIS_EXP_NONE_N = 4'hf;
    typedef enum logic [1:0] {AIS_IDLE, AIS_SETTLE, AIS_BITS} ais_sar_e;
endpackage

// ### ais_sar.sv
// successive-approximation engine stepped by the converter clock tick
`timescale 1ns/1ps
module ais_sar import ais_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // control
    input wire logic tick,
    input wire logic start,
    input wire logic cmp_hi,
    // results
    output logic [11:0] dac_code,
    output logic done,
    output logic [11:0] result
);
    typedef struct packed {
        ais_sar_e st;
        logic [5:0] cnt;
        logic [11:0] sar;
        logic [11:0] bitm;
        logic done;
        logic [11:0] res;
        logic [5:0] tcnt;
    } ais_sar_s;

    ais_sar_s s_ff, nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        if (tick && s_ff.st != AIS_IDLE) begin
            nxt_s.tcnt = s_ff.tcnt + 6'h01;
        end
        case (s_ff.st)
            AIS_IDLE: begin
            end
            AIS_SETTLE: begin
                if (tick) begin
                    nxt_s.cnt = s_ff.cnt - 6'h01;
                    if (s_ff.cnt == 6'h01) begin
                        nxt_s.st = AIS_BITS;
                        nxt_s.bitm = 12'h800;
                        nxt_s.sar = 12'h800;
                    end
                end
            end
            AIS_BITS: begin
                if (tick) begin
                    // comparator high means input at or above the trial code
                    if (!cmp_hi) begin
                        nxt_s.sar = s_ff.sar & ~s_ff.bitm;
                    end
                    nxt_s.bitm = s_ff.bitm >> 1;
                    nxt_s.sar = nxt_s.sar | (s_ff.bitm >> 1);
                    if (s_ff.bitm == 12'h001) begin
                        nxt_s.st = AIS_IDLE;
                        nxt_s.done = 1'b1;
                        nxt_s.res = cmp_hi ? s_ff.sar : (s_ff.sar & ~s_ff.bitm);
                    end
                end
            end
            default: nxt_s.st = AIS_IDLE;
        endcase
        // a new command aborts whatever was running
        if (start) begin
            nxt_s.st = AIS_SETTLE;
            nxt_s.cnt = AIS_SETTLE_TICKS;
            nxt_s.sar = 12'h000;
            nxt_s.tcnt = 6'h00;
            nxt_s.done = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_ff <= '0;
        end else if (clk_en) begin
            s_ff <= nxt_s;
        end
    end

    assign dac_code = s_ff.sar;
    assign done = s_ff.done;
    assign result = s_ff.res;

    AST_CONV_TICKS: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(s_ff.done) |-> s_ff.tcnt == AIS_CONV_TICKS)
        else $error("conversion length differs from 50 us in ticks");
    AST_IDLE_AFTER_DONE: assert property (@(posedge clk) disable iff (!reset_n)
        s_ff.done |-> s_ff.st == AIS_IDLE || $past(start))
        else $error("engine still running after done");
endmodule

// ### ais_sequencer.sv
// analog input sequencer: command port, result ports, expansion selects
// Function
// - command write starts a conversion with channel and gain from that byte
// - gains 1 and 5 finish and flag done about 50 us after the write
// - the repeated high-gain command completes a conversion and flags done
// - single-ended: bits 3..0 pick input, bit 4 connector, bit 5 ignored
// - bits 7..6 select gain 1, 5, 50, 250 in both modes
// - differential: bits 3..0 pick input, bits 5..4 drive expansion only
// - low port reads low result byte, high port reads high byte
// - result left-justified; high byte bits 11..4, low 7..4 bits 3..0, bit 0 done
// - result is straight binary, offset binary in bipolar range
// - done bit reads 0 when conversion ended, 1 while in progress
// - differential: bits 5..4 decode to four active-low selects, one active
// - old select goes inactive 400 ns before new one goes active
// - expansion selects only used in differential mode, up to 64 channels
// - conversion logic clocked by a 1.024 MHz derived clock
`timescale 1ns/1ps
module ais_sequencer import ais_pkg::*; (
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // host byte i/o port
    input wire logic [7:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // analog front end
    input wire logic diff_mode_pin,
    input wire logic cmp_pin,
    output logic [3:0] input_select,
    output logic upper_input_connector,
    output logic [1:0] gain_select,
    output logic [11:0] dac_code,
    // off-board multiplexer expansion
    output logic [3:0] exp_select_n
);
    typedef struct packed {
        logic [7:0] cmd;
        logic [11:0] res;
        logic busy;
        logic [3:0] exp_n;
        logic [6:0] gap;
        logic [17:0] acc;
        logic tick;
        logic [7:0] rdata;
        logic cmp_s1;
        logic cmp_s2;
        logic diff_s1;
        logic diff_s2;
    } ais_top_s;

    ais_top_s s_ff, nxt_s;
    logic cmd_wr;
    logic sar_done;
    logic [11:0] sar_res;
    logic [17:0] acc_sum;

    function automatic logic [3:0] exp_decode(input logic diff, input logic [1:0] sel);
        logic [3:0] v;
        v = AIS_EXP_NONE_N;
        if (diff) begin
            v[sel] = 1'b0;
        end
        return v;
    endfunction

    assign cmd_wr = io_wr && io_addr == AIS_CONVERSION_COMMAND_ADDR;
    assign acc_sum = s_ff.acc + AIS_ACC_STEP;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.cmp_s1 = cmp_pin;
        nxt_s.cmp_s2 = s_ff.cmp_s1;
        nxt_s.diff_s1 = diff_mode_pin;
        nxt_s.diff_s2 = s_ff.diff_s1;
        // fractional divider, jitter of one fast cycle is harmless to the sar
        nxt_s.tick = 1'b0;
        nxt_s.acc = acc_sum;
        if (acc_sum >= AIS_ACC_WRAP) begin
            nxt_s.acc = acc_sum - AIS_ACC_WRAP;
            nxt_s.tick = 1'b1;
        end
        if (sar_done) begin
            nxt_s.res = sar_res;
            nxt_s.busy = 1'b0;
        end
        // a write in the same cycle as done keeps busy set
        if (cmd_wr) begin
            nxt_s.cmd = io_wdata;
            nxt_s.busy = 1'b1;
        end
        // selects break first, then make after the gap
        if (cmd_wr) begin
            nxt_s.exp_n = AIS_EXP_NONE_N;
            nxt_s.gap = AIS_EXP_GAP_CYC;
        end else if (s_ff.gap != 7'h00) begin
            nxt_s.gap = s_ff.gap - 7'h01;
        end else begin
            nxt_s.exp_n = exp_decode(s_ff.diff_s2, s_ff.cmd[AIS_CMD_EXP_LSB +: 2]);
        end
        if (io_rd) begin
            case (io_addr)
                AIS_RESULT_LOW_AND_DONE_ADDR: begin
                    nxt_s.rdata = 8'h00;
                    nxt_s.rdata[AIS_LOW_RES_LSB +: 4] = s_ff.res[3:0];
                    nxt_s.rdata[AIS_LOW_DONE_BIT] = s_ff.busy;
                end
                AIS_RESULT_HIGH_ADDR: nxt_s.rdata = s_ff.res[11:4];
                default: nxt_s.rdata = AIS_UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_ff <= '0;
            s_ff.cmd <= AIS_CMD_RESET;
            s_ff.exp_n <= AIS_EXP_NONE_N;
        end else if (clk_en) begin
            s_ff <= nxt_s;
        end
    end

    ais_sar u_sar (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .tick(s_ff.tick),
        .start(cmd_wr),
        .cmp_hi(s_ff.cmp_s2),
        .dac_code(dac_code),
        .done(sar_done),
        .result(sar_res)
    );

    assign io_rdata = s_ff.rdata;
    assign input_select = s_ff.cmd[AIS_CMD_CHAN_LSB +: 4];
    // connector bit only steers the on-board mux in single-ended mode
    assign upper_input_connector = s_ff.cmd[AIS_CMD_CONN_BIT] & ~s_ff.diff_s2;
    assign gain_select = s_ff.cmd[AIS_CMD_GAIN_LSB +: 2];
    assign exp_select_n = s_ff.exp_n;

    AST_CMD_CAPTURE: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_wr && clk_en |=> s_ff.cmd == $past(io_wdata) && s_ff.busy)
        else $error("command not captured or busy not set");
    AST_BUSY_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
        s_ff.busy && !sar_done |=> s_ff.busy)
        else $error("busy dropped before result latched");
    AST_BREAK: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_wr && clk_en |=> s_ff.exp_n == AIS_EXP_NONE_N)
        else $error("expansion select not released on write");
    AST_GAP: assert property (@(posedge clk) disable iff (!reset_n)
        s_ff.gap != 7'h00 |-> s_ff.exp_n == AIS_EXP_NONE_N)
        else $error("expansion select made during gap");
    AST_ONEHOT: assert property (@(posedge clk) disable iff (!reset_n)
        // selects follow the synchronised mode one cycle late
        s_ff.exp_n != AIS_EXP_NONE_N |-> $onehot(~s_ff.exp_n) && $past(s_ff.diff_s2))
        else $error("expansion selects not one-hot or not differential");
    AST_LOW_READ: assert property (@(posedge clk) disable iff (!reset_n)
        io_rd && clk_en && io_addr == AIS_RESULT_LOW_AND_DONE_ADDR
        |=> io_rdata[3:1] == 3'h0 && io_rdata[0] == $past(s_ff.busy)
            && io_rdata[7:4] == $past(s_ff.res[3:0]))
        else $error("low byte read wrong");
    AST_HIGH_READ: assert property (@(posedge clk) disable iff (!reset_n)
        io_rd && clk_en && io_addr == AIS_RESULT_HIGH_ADDR |=> io_rdata == $past(s_ff.res[11:4]))
        else $error("high byte read wrong");
    AST_DONE_LATCH: assert property (@(posedge clk) disable iff (!reset_n)
        sar_done && clk_en && !cmd_wr |=> !s_ff.busy && s_ff.res == $past(sar_res))
        else $error("result not latched on done");

    // host port checks
    AST_CHAN_SEL: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_wr && clk_en |=> input_select == $past(io_wdata[AIS_CMD_CHAN_LSB +: 4]))
        else $error("channel select not taken from command");
    AST_GAIN_SEL: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_wr && clk_en |=> gain_select == $past(io_wdata[AIS_CMD_GAIN_LSB +: 2]))
        else $error("gain select not taken from command");
    AST_CONN_SINGLE: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_wr && clk_en && !s_ff.diff_s1 |=> upper_input_connector == $past(io_wdata[AIS_CMD_CONN_BIT]))
        else $error("connector select not taken from command");
    AST_CONN_DIFF: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_wr && clk_en && s_ff.diff_s1 |=> !upper_input_connector)
        else $error("connector select driven in differential mode");
    AST_WR_OTHER: assert property (@(posedge clk) disable iff (!reset_n)
        io_wr && clk_en && io_addr != AIS_CONVERSION_COMMAND_ADDR |=> $stable(s_ff.cmd))
        else $error("write to another port changed the command");
    AST_UNMAPPED: assert property (@(posedge clk) disable iff (!reset_n)
        io_rd && clk_en && io_addr != AIS_RESULT_LOW_AND_DONE_ADDR && io_addr != AIS_RESULT_HIGH_ADDR
        |=> io_rdata == AIS_UNMAPPED_READ)
        else $error("unmapped read not zero");
    AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
        !(io_rd && clk_en) |=> $stable(io_rdata))
        else $error("read data changed without a read");
    AST_START_CLEARS: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_wr && clk_en |=> !sar_done)
        else $error("stale done after a new command");
    AST_RES_STABLE: assert property (@(posedge clk) disable iff (!reset_n)
        !(sar_done && clk_en) |=> $stable(s_ff.res))
        else $error("result changed without a finished conversion");

    // expansion select checks
    AST_MAKE: assert property (@(posedge clk) disable iff (!reset_n)
        s_ff.gap == 7'h00 && s_ff.diff_s2 && !cmd_wr && clk_en
        |=> exp_select_n == ~(4'h1 << $past(s_ff.cmd[AIS_CMD_EXP_LSB +: 2])))
        else $error("expansion select not made after the gap");
    AST_SINGLE_NONE: assert property (@(posedge clk) disable iff (!reset_n)
        !s_ff.diff_s2 && !$past(s_ff.diff_s2) |-> exp_select_n == AIS_EXP_NONE_N)
        else $error("expansion select active in single-ended mode");

    // a frozen enable stretches the tick spacing, so it also switches the spacing check off
    AST_TICK_RATE: assert property (@(posedge clk) disable iff (!reset_n || !clk_en)
        s_ff.tick |-> ##[195:196] s_ff.tick)
        else $error("converter tick spacing wrong");
    AST_ACC_RANGE: assert property (@(posedge clk) disable iff (!reset_n)
        s_ff.acc < AIS_ACC_WRAP)
        else $error("phase accumulator out of range");
endmodule

// ### ais_front_model.sv
// analog front end stand-in: comparator against a held input level
`timescale 1ns/1ps
module ais_front_model (
    // converter side
    input wire logic [11:0] dac_code,
    input wire logic [11:0] level,
    // comparator output
    output logic cmp_pin
);
    // ideal comparator, no offset; a trial code at or under the level reads high
    assign cmp_pin = (level >= dac_code);
endmodule

// ### ais_sequencer_bench.sv
// self-checking bench for the analog input sequencer
`timescale 1ns/1ps
module ais_sequencer_bench import ais_pkg::*; ;
    logic clk, reset_n, clk_en, io_wr, io_rd, diff_mode_pin, cmp_pin, upper_input_connector;
    logic [7:0] io_addr, io_wdata, io_rdata, d, cmd;
    logic [3:0] input_select, exp_select_n, sel;
    logic [1:0] gain_select;
    logic [11:0] dac_code, level, got, ref_val;
    logic [31:0] r;
    int err_total, comparisons;

    ais_sequencer DUT (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .diff_mode_pin(diff_mode_pin),
        .cmp_pin(cmp_pin), .input_select(input_select), .upper_input_connector(upper_input_connector),
        .gain_select(gain_select), .dac_code(dac_code), .exp_select_n(exp_select_n));
    ais_front_model u_front (.dac_code(dac_code), .level(level), .cmp_pin(cmp_pin));

    always #2.5 clk = ~clk;

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        io_addr <= a;
        io_wdata <= v;
        io_wr <= 1'b1;
        @(posedge clk);
        io_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge clk);
        io_rd <= 1'b0;
        @(posedge clk);
        #1 v = io_rdata;
    endtask

    function automatic logic [7:0] low_of(input logic [11:0] res);
        return {res[3:0], 3'b000, 1'b0};
    endfunction

    // host-side offset correction; modular arithmetic covers either offset sign
    function automatic logic [11:0] offset_fix(input logic [11:0] reading, input logic [11:0] refr);
        return reading - (refr - 12'h800);
    endfunction

    // high-gain settling wait shortened: 1 ms or 10 ms would overrun the run budget
    task automatic convert(input logic [7:0] c, input logic [11:0] lv, input bit again, output logic [11:0] res);
        logic [7:0] v;
        time t0;
        int n;
        level = lv;
        wr(AIS_CONVERSION_COMMAND_ADDR, c);
        @(posedge clk);
        #1 check(input_select, c[3:0]);
        check(upper_input_connector, c[4]);
        check(gain_select, c[7:6]);
        check(exp_select_n, AIS_EXP_NONE_N);
        check(dac_code, 12'h000);
        rd(AIS_RESULT_LOW_AND_DONE_ADDR, v);
        check(v[0], 1'b1);
        if (again) begin
            // no other channel is started while the amplifier settles
            repeat (1000) @(posedge clk);
            wr(AIS_CONVERSION_COMMAND_ADDR, c);
        end
        t0 = $time;
        n = 0;
        while (v[0] !== 1'b0 && n < 5000) begin
            rd(AIS_RESULT_LOW_AND_DONE_ADDR, v);
            n++;
        end
        check(($time - t0 > 48000) && ($time - t0 < 52000), 1'b1);
        check(v, low_of(lv));
        res[3:0] = v[7:4];
        rd(AIS_RESULT_HIGH_ADDR, v);
        check(v, lv[11:4]);
        res[11:4] = v;
        check(dac_code, lv);
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        report_and_stop();
    end

    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        io_addr = 8'h00;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
        clk_en = 1'b1;
        diff_mode_pin = 1'b0;
        level = 12'h000;
        err_total = 0;
        comparisons = 0;
        r = $urandom(32'h58fb);
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        #1 check(exp_select_n, AIS_EXP_NONE_N);
        rd(AIS_RESULT_LOW_AND_DONE_ADDR, d);
        check(d, 8'h00);
        rd(8'hd0, d);
        check(d, AIS_UNMAPPED_READ);
        wr(AIS_RESULT_HIGH_ADDR, 8'h3f);
        rd(AIS_RESULT_LOW_AND_DONE_ADDR, d);
        check(d[0], 1'b0);
        r = $urandom;
        convert({2'b00, r[5:0]}, r[19:8], 1'b0, got);
        cmd = {2'b11, r[13:8]};
        // reference channel five codes above midscale: a positive offset
        convert(cmd, 12'h805, 1'b1, ref_val);
        convert({cmd[7:4], ~cmd[3:0]}, 12'hfff, 1'b1, got);
        check(offset_fix(got, ref_val), 12'hffa);
        @(posedge clk);
        diff_mode_pin <= 1'b1;
        repeat (100) @(posedge clk);
        sel = ~(4'h1 << cmd[5:4]);
        #1 check(exp_select_n, sel);
        for (int k = 0; k < 4; k++) begin
            wr(AIS_CONVERSION_COMMAND_ADDR, {k[1:0], k[1:0], r[3:0]});
            @(posedge clk);
            #1 check(exp_select_n, 4'hf);
            check(upper_input_connector, 1'b0);
            check(gain_select, k[1:0]);
            repeat (78) @(posedge clk);
            #1 check(exp_select_n, 4'hf);
            repeat (3) @(posedge clk);
            sel = ~(4'h1 << k);
            #1 check(exp_select_n, sel);
        end
        // a frozen enable must drop the write and hold the gain and expansion selects
        @(posedge clk);
        clk_en <= 1'b0;
        wr(AIS_CONVERSION_COMMAND_ADDR, 8'h00);
        repeat (2) @(posedge clk);
        #1 check(gain_select, 2'b11);
        check(exp_select_n, 4'h7);
        @(posedge clk);
        clk_en <= 1'b1;
        report_and_stop();
    end
endmodule
